//--- src/cam_table_counter_routing.sv
`timescale 1ns/1ps

// What this block does
// - Bit ten adds second cam into global
// - Bit twelve adds positioner into reference
// - Bit thirteen adds first cam into reference
// - Bit fourteen adds second cam into reference
// - Bit fifteen adds speed count into reference
// - Bit zero arms table zero at phase
// - Bit one arms table one at phase
// - Bit two arms table two at phase
// - Bit three arms table three at phase
// - Bit four engages table zero at once
// - Bit five engages table one at once
// - Bit six engages table two at once
// - Bit seven engages table three at once
// - Bit eight shows table zero in use
// - Bit ten shows table three in use
// - Bit nine adds first cam into global
module cam_table_counter_routing (
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Motion counters and master phase, same clock
    input wire logic [31:0] positioner_count,
    input wire logic [31:0] first_cam_count,
    input wire logic [31:0] second_cam_count,
    input wire logic [31:0] speed_mode_count,
    input wire logic [31:0] master_phase,
    // Results
    output logic [31:0] global_position_counter,
    output logic [31:0] position_reference_value,
    output logic [3:0] cam_table_select,
    output logic irq
);

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // 0x00 routing: bits 9 and 10 feed the global counter,
    //   bits 12 to 15 feed the position reference
    // 0x04 cam control: arm bits 3:0, immediate bits 7:4,
    //   read-only in-use bits 8, 9, 11, 10 for tables zero to three
    // 0x08 engage flags, one per table, write one to clear
    // 0x0c engage flag mask, same layout as the flags
    // 0x10 to 0x1c engage phase of tables zero to three
    // Upper half of each 16-bit word reads as zero
    // Unmapped words read zero and answer with an error

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] routing;          // Counter routing control
        logic [3:0] arm;               // Tables waiting for phase
        logic [3:0] immediate;         // Pending immediate engages
        logic [3:0] in_use;            // Table used by first generator
        logic [3:0][31:0] phase;       // Engage phase per table
        logic [3:0] irq_sts;           // Sticky engage flags
        logic [3:0] irq_msk;           // Engage flag mask
        logic [31:0] prdata;           // Read data captured in setup
        logic pslverr;                 // Unmapped address flag
        logic [31:0] gpc;              // Global position counter
        logic [31:0] prv;              // Position reference value
    } state_t;

    state_t s_r;    // Registered state
    state_t s_nxt;  // Next state

    logic [3:0] hit;         // Armed table whose phase is reached
    logic [3:0] engage;      // One-hot table engaged this cycle
    logic [15:0] camctl_rd;  // Read view of cam control word
    logic setup_ph;          // APB setup cycle
    logic wr_acc;            // APB write taking effect

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;

    // Short names for the field positions used in slices
    localparam int ARM_POS = cam_routing_pkg::ARM_POS;
    localparam int IMMEDIATE_POS = cam_routing_pkg::IMMEDIATE_POS;

    // ------------------------------------------------------------
    // Per-table phase compare
    // ------------------------------------------------------------
    // Reaching means at or beyond the phase, so a master that jumps
    // over the exact value still engages the table
    // A table whose phase word is zero engages as soon as it is armed
    for (genvar i = 0; i < 4; i++) begin : g_cmp
        assign hit[i] = s_r.arm[i] && (master_phase >= s_r.phase[i]);
    end

    // ------------------------------------------------------------
    // Engage arbitration
    // ------------------------------------------------------------
    // Immediate requests beat phase hits; lowest table index wins.
    // Only one table engages per cycle, since the first generator
    // can run from one table at a time.
    // A losing request stays pending and is served in a later cycle.
    always_comb begin
        engage = 4'h0;
        if (s_r.immediate != 4'h0) begin
            engage = s_r.immediate & (~s_r.immediate + 4'h1);
        end else if (hit != 4'h0) begin
            engage = hit & (~hit + 4'h1);
        end
    end

    // Status positions, table two and three sit out of index order
    // Arm and immediate bits read back while they are still pending
    always_comb begin
        camctl_rd = 16'h0000;
        camctl_rd[ARM_POS+:4] = s_r.arm;
        camctl_rd[IMMEDIATE_POS+:4] = s_r.immediate;
        camctl_rd[cam_routing_pkg::USE_T0_POS] = s_r.in_use[0];
        camctl_rd[cam_routing_pkg::USE_T1_POS] = s_r.in_use[1];
        camctl_rd[cam_routing_pkg::USE_T2_POS] = s_r.in_use[2];
        camctl_rd[cam_routing_pkg::USE_T3_POS] = s_r.in_use[3];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Every register of the block moves here; the flop below only
    // copies the result, so hold behaviour stays in one place
    always_comb begin
        s_nxt = s_r;

        // Counter sums, registered one cycle after the inputs
        s_nxt.gpc = 32'h0000_0000;
        if (s_r.routing[cam_routing_pkg::GLB_FIRST_CAM_POS]) begin
            s_nxt.gpc = s_nxt.gpc + first_cam_count;
        end
        if (s_r.routing[cam_routing_pkg::GLB_SECOND_CAM_POS]) begin
            s_nxt.gpc = s_nxt.gpc + second_cam_count;
        end
        s_nxt.prv = 32'h0000_0000;
        if (s_r.routing[cam_routing_pkg::REF_POSITIONER_POS]) begin
            s_nxt.prv = s_nxt.prv + positioner_count;
        end
        if (s_r.routing[cam_routing_pkg::REF_FIRST_CAM_POS]) begin
            s_nxt.prv = s_nxt.prv + first_cam_count;
        end
        if (s_r.routing[cam_routing_pkg::REF_SECOND_CAM_POS]) begin
            s_nxt.prv = s_nxt.prv + second_cam_count;
        end
        if (s_r.routing[cam_routing_pkg::REF_SPEED_POS]) begin
            s_nxt.prv = s_nxt.prv + speed_mode_count;
        end

        // Hardware side of engagement first, so a software set wins
        if (engage != 4'h0) begin
            s_nxt.in_use = engage;
            s_nxt.arm = s_r.arm & ~engage;
            s_nxt.immediate = s_r.immediate & ~engage;
        end

        // Read data captured in the setup cycle, stable in access
        // so prdata leaves a flop and needs no address path in access
        if (setup_ph) begin
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata = 32'h0000_0000;
            case (paddr)
                cam_routing_pkg::ROUTING_OFS: begin
                    s_nxt.prdata = {16'h0000, s_r.routing};
                end
                cam_routing_pkg::CAMCTL_OFS: begin
                    s_nxt.prdata = {16'h0000, camctl_rd};
                end
                cam_routing_pkg::IRQ_STS_OFS: begin
                    s_nxt.prdata = {28'h000_0000, s_r.irq_sts};
                end
                cam_routing_pkg::IRQ_MSK_OFS: begin
                    s_nxt.prdata = {28'h000_0000, s_r.irq_msk};
                end
                cam_routing_pkg::PHASE_BASE_OFS: begin
                    s_nxt.prdata = s_r.phase[0];
                end
                cam_routing_pkg::PHASE_BASE_OFS + 8'h04: begin
                    s_nxt.prdata = s_r.phase[1];
                end
                cam_routing_pkg::PHASE_BASE_OFS + 8'h08: begin
                    s_nxt.prdata = s_r.phase[2];
                end
                cam_routing_pkg::PHASE_BASE_OFS + 8'h0c: begin
                    s_nxt.prdata = s_r.phase[3];
                end
                default: begin
                    // Unmapped: reads zero, answers with an error
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // Sticky engage flags, write one to clear
        // Flags feed the level interrupt through the mask
        if (wr_acc && paddr == cam_routing_pkg::IRQ_STS_OFS) begin
            s_nxt.irq_sts = s_r.irq_sts & ~pwdata[3:0];
        end
        // Set after clear: an engage in the clearing cycle is kept
        s_nxt.irq_sts = s_nxt.irq_sts | engage;

        // Register writes at the access edge
        // A cam control write in the same cycle as an engage overrides the arm bits
        if (wr_acc) begin
            case (paddr)
                cam_routing_pkg::ROUTING_OFS: begin
                    s_nxt.routing = pwdata[15:0];
                end
                cam_routing_pkg::CAMCTL_OFS: begin
                    // In-use bits ignore the write
                    s_nxt.arm = pwdata[ARM_POS+:4];
                    s_nxt.immediate = pwdata[IMMEDIATE_POS+:4];
                end
                cam_routing_pkg::IRQ_MSK_OFS: begin
                    s_nxt.irq_msk = pwdata[3:0];
                end
                cam_routing_pkg::PHASE_BASE_OFS: begin
                    s_nxt.phase[0] = pwdata;
                end
                cam_routing_pkg::PHASE_BASE_OFS + 8'h04: begin
                    s_nxt.phase[1] = pwdata;
                end
                cam_routing_pkg::PHASE_BASE_OFS + 8'h08: begin
                    s_nxt.phase[2] = pwdata;
                end
                cam_routing_pkg::PHASE_BASE_OFS + 8'h0c: begin
                    s_nxt.phase[3] = pwdata;
                end
                default: begin
                    // Flag word is cleared by write one above; unmapped words keep their value
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Synchronous reset clears every field first, then loads the
    // named reset values so a changed default lands in one place
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.routing <= cam_routing_pkg::ROUTING_RST;
            s_r.arm <= cam_routing_pkg::ARM_RST;
            s_r.immediate <= cam_routing_pkg::IMMEDIATE_RST;
            s_r.in_use <= cam_routing_pkg::IN_USE_RST;
            s_r.phase <= {4{cam_routing_pkg::PHASE_RST}};
            s_r.irq_msk <= cam_routing_pkg::IRQ_MSK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero wait states: the answer is ready in every access cycle
    // The error flag is gated so that it only shows in the access
    // phase, while the captured flag itself may linger until setup
    assign pready = 1'b1;
    assign pslverr = s_r.pslverr && psel && penable;
    assign prdata = s_r.prdata;
    assign global_position_counter = s_r.gpc;
    assign position_reference_value = s_r.prv;
    assign cam_table_select = s_r.in_use;
    assign irq = |(s_r.irq_sts & s_r.irq_msk);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Checks sample at the rising edge and sleep through reset; sums
    // are compared against the inputs one edge earlier, matching the
    // single register stage in front of each counter output

    a_global_first_cam: assert property (
        $past({s_r.routing[10], s_r.routing[9]}) == 2'b01
        |-> global_position_counter == $past(first_cam_count))
        else $error("global counter missing first cam count");

    a_global_second_cam: assert property (
        $past(s_r.routing[10:9]) == 2'b10 |-> global_position_counter == $past(second_cam_count))
        else $error("global counter missing second cam count");

    a_ref_positioner: assert property (
        $past(s_r.routing[15:12]) == 4'h1 |-> position_reference_value == $past(positioner_count))
        else $error("reference missing positioner count");

    a_ref_first_cam: assert property (
        $past(s_r.routing[15:12]) == 4'h2 |-> position_reference_value == $past(first_cam_count))
        else $error("reference missing first cam count");

    a_ref_second_cam: assert property (
        $past(s_r.routing[15:12]) == 4'h4 |-> position_reference_value == $past(second_cam_count))
        else $error("reference missing second cam count");

    a_ref_speed_count: assert property (
        $past(s_r.routing[15:12]) == 4'h8 |-> position_reference_value == $past(speed_mode_count))
        else $error("reference missing speed mode count");

    for (genvar k = 0; k < 4; k++) begin : g_chk
        a_phase_engage: assert property (
            s_r.immediate == 4'h0 && hit[k] && (hit & ((4'h1 << k) - 4'h1)) == 4'h0
            |=> cam_table_select == (4'h1 << k) && !s_r.arm[k] && s_r.irq_sts[k])
            else $error("armed table did not engage at its phase");

        // A table waits armed until its phase comes or software disarms it
        a_arm_waits: assert property (
            s_r.arm[k] && !hit[k] && !s_r.immediate[k]
            && !(wr_acc && paddr == cam_routing_pkg::CAMCTL_OFS) |=> s_r.arm[k])
            else $error("armed table dropped before its phase");

        a_immediate_engage: assert property (
            s_r.immediate[k] && (s_r.immediate & ((4'h1 << k) - 4'h1)) == 4'h0
            |=> cam_table_select == (4'h1 << k))
            else $error("immediate request did not engage table");
    end

    a_status_readback: assert property (
        setup_ph && paddr == cam_routing_pkg::CAMCTL_OFS
        |=> prdata[8] == $past(s_r.in_use[0]) && prdata[10] == $past(s_r.in_use[3]))
        else $error("in-use status bits misreported");

    a_status_read_only: assert property (
        wr_acc && paddr == cam_routing_pkg::CAMCTL_OFS && engage == 4'h0
        |=> $stable(cam_table_select))
        else $error("software write changed in-use status");

    a_irq_level: assert property (
        $rose(irq) |-> $past((s_r.irq_sts | engage) != 4'h0) && (s_r.irq_sts & s_r.irq_msk) != 4'h0)
        else $error("interrupt raised without unmasked flag");

    // In-use status only moves on an engage, never on its own
    a_select_holds: assert property (
        engage == 4'h0 |=> $stable(cam_table_select))
        else $error("in-use status changed without an engage");

    // Write one clears a flag unless an engage sets it in that cycle
    a_flag_clear: assert property (
        wr_acc && paddr == cam_routing_pkg::IRQ_STS_OFS
        |=> (s_r.irq_sts & $past(pwdata[3:0] & ~engage)) == 4'h0)
        else $error("write one did not clear engage flag");

    // Refused words never leak data
    a_unmapped_zero: assert property (
        psel && penable && pslverr |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    // A routing write lands whole at the access edge
    a_routing_write: assert property (
        wr_acc && paddr == cam_routing_pkg::ROUTING_OFS
        |=> s_r.routing == $past(pwdata[15:0]))
        else $error("routing write did not land");

    // Bits 9 and 10 clear leave the global counter at zero
    a_global_idle: assert property (
        $past({s_r.routing[10], s_r.routing[9]}) == 2'b00
        |-> global_position_counter == 32'h0000_0000)
        else $error("global counter summed a disabled count");

    // Bits 12 to 15 clear leave the position reference at zero
    a_ref_idle: assert property (
        $past(s_r.routing[15:12]) == 4'h0
        |-> position_reference_value == 32'h0000_0000)
        else $error("reference summed a disabled count");

endmodule

//--- src/cam_routing_pkg.sv
package cam_routing_pkg;

    // ------------------------------------------------------------
    // Register byte offsets (APB, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ROUTING_OFS = 8'h00;     // Counter routing control
    localparam logic [7:0] CAMCTL_OFS = 8'h04;      // Cam table control and status
    localparam logic [7:0] IRQ_STS_OFS = 8'h08;     // Engage event flags, write one to clear
    localparam logic [7:0] IRQ_MSK_OFS = 8'h0c;     // Engage event mask
    localparam logic [7:0] PHASE_BASE_OFS = 8'h10;  // Four engage phases, 4 bytes apart

    // ------------------------------------------------------------
    // Routing word bit positions
    // ------------------------------------------------------------
    localparam int GLB_FIRST_CAM_POS = 9;    // First cam count into global counter
    localparam int GLB_SECOND_CAM_POS = 10;  // Second cam count into global counter
    localparam int REF_POSITIONER_POS = 12;  // Positioner count into reference
    localparam int REF_FIRST_CAM_POS = 13;   // First cam count into reference
    localparam int REF_SECOND_CAM_POS = 14;  // Second cam count into reference
    localparam int REF_SPEED_POS = 15;       // Speed mode count into reference

    // ------------------------------------------------------------
    // Cam control word bit positions
    // ------------------------------------------------------------
    localparam int ARM_POS = 0;          // Bits 3:0 arm tables at phase
    localparam int IMMEDIATE_POS = 4;    // Bits 7:4 engage tables at once
    localparam int USE_T0_POS = 8;       // Table zero in use
    localparam int USE_T1_POS = 9;       // Table one in use
    localparam int USE_T2_POS = 11;      // Table two in use
    localparam int USE_T3_POS = 10;      // Table three in use

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [15:0] ROUTING_RST = 16'h0000;
    localparam logic [3:0] ARM_RST = 4'h0;
    localparam logic [3:0] IMMEDIATE_RST = 4'h0;
    localparam logic [3:0] IN_USE_RST = 4'h0;
    localparam logic [31:0] PHASE_RST = 32'h0000_0000;
    localparam logic [3:0] IRQ_MSK_RST = 4'h0;

endpackage

//--- sim/cam_table_counter_routing_tb.sv
`timescale 1ns/1ps

// Compare macro: counts every comparison, reports and counts mismatches
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); end end

module cam_table_counter_routing_tb;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;           // 10 MHz bench clock
    logic sys_rst = 1'b1;       // Held high at start
    logic psel = 1'b0;          // APB select
    logic penable = 1'b0;       // APB access phase
    logic pwrite = 1'b0;        // APB direction
    logic [7:0] paddr = 8'h00;  // APB byte address
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] pos_cnt = 32'h0000_0011;     // Distinct values so sums stay unique
    logic [31:0] first_profile_generator_cnt = 32'h0000_0220;
    logic [31:0] second_profile_generator_cnt = 32'h0000_3300;
    logic [31:0] speed_cnt = 32'h0004_4000;
    logic [31:0] master_phase = 32'h0000_0000;
    logic [31:0] global_position_counter;
    logic [31:0] position_reference_value;
    logic [3:0] cam_table_select;
    logic irq;
    int num_errors = 0;        // Mismatches
    int check_count = 0;       // Comparisons made
    logic [31:0] rd;           // Last read data
    logic err;                 // Last slave error
    int use_pos [4];           // In-use bit position per table

    // ------------------------------------------------------------
    // Design under test
    // ------------------------------------------------------------
    cam_table_counter_routing cam_table_counter_routing_inst (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .positioner_count(pos_cnt), .first_cam_count(first_profile_generator_cnt),
        .second_cam_count(second_profile_generator_cnt), .speed_mode_count(speed_cnt),
        .master_phase(master_phase), .global_position_counter(global_position_counter),
        .position_reference_value(position_reference_value),
        .cam_table_select(cam_table_select), .irq(irq)
    );

    // Free running clock, 100 ns period
    always #50 clk = ~clk;

    // ------------------------------------------------------------
    // Bus tasks and closing
    // ------------------------------------------------------------
    // One APB transfer; waits on pready, no assumed latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Settle just after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every routing bit alone, then all at once
    task automatic routing_test();
        logic [15:0] tbl [7];
        logic [31:0] g;
        logic [31:0] r;
        tbl = '{16'h0200, 16'h0400, 16'h1000, 16'h2000, 16'h4000, 16'h8000, 16'hf600};
        apb(1'b0, cam_routing_pkg::ROUTING_OFS, 32'h0);
        `CHK(rd, 32'h0)
        foreach (tbl[i]) begin
            apb(1'b1, cam_routing_pkg::ROUTING_OFS, {16'h0000, tbl[i]});
            tick(2);
            g = (tbl[i][9] ? first_profile_generator_cnt : 32'h0) + (tbl[i][10] ? second_profile_generator_cnt : 32'h0);
            r = (tbl[i][12] ? pos_cnt : 32'h0) + (tbl[i][13] ? first_profile_generator_cnt : 32'h0)
                + (tbl[i][14] ? second_profile_generator_cnt : 32'h0) + (tbl[i][15] ? speed_cnt : 32'h0);
            `CHK(global_position_counter, g)
            `CHK(position_reference_value, r)
        end
        // Counter change must show by the second edge after the input moves
        @(posedge clk);
        first_profile_generator_cnt <= 32'hffff_fff0;
        tick(2);
        `CHK(global_position_counter, 32'hffff_fff0 + second_profile_generator_cnt)
    endtask

    // Immediate engage of each table, event flags and interrupt
    task automatic immediate_test();
        logic [31:0] ev;
        apb(1'b1, cam_routing_pkg::IRQ_MSK_OFS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, cam_routing_pkg::CAMCTL_OFS, 32'h1 << (4 + i));
            tick(1);
            `CHK(cam_table_select, 4'h1 << i)
            apb(1'b0, cam_routing_pkg::CAMCTL_OFS, 32'h0);
            `CHK(rd, 32'h1 << use_pos[i])
            `CHK(irq, 1'b0)
        end
        ev = 32'h0000_000f;
        apb(1'b0, cam_routing_pkg::IRQ_STS_OFS, 32'h0);
        `CHK(rd, ev)
        apb(1'b1, cam_routing_pkg::IRQ_MSK_OFS, 32'h1);
        tick(1);
        `CHK(irq, 1'b1)
        apb(1'b1, cam_routing_pkg::IRQ_STS_OFS, 32'h1);
        tick(1);
        `CHK(irq, 1'b0)
        apb(1'b0, cam_routing_pkg::IRQ_STS_OFS, 32'h0);
        `CHK(rd, 32'h0000_000e)
        apb(1'b1, cam_routing_pkg::IRQ_STS_OFS, 32'he);
    endtask

    // Armed engage at the exact phase boundary
    task automatic armed_test();
        logic [7:0] pa;
        for (int i = 0; i < 4; i++) begin
            pa = cam_routing_pkg::PHASE_BASE_OFS + 8'(4 * i);
            apb(1'b1, pa, 32'h0000_0100);
            @(posedge clk);
            master_phase <= 32'h0000_00ff;
            apb(1'b1, cam_routing_pkg::CAMCTL_OFS, 32'h1 << i);
            tick(3);
            `CHK(cam_table_select, (i == 0) ? 4'h8 : (4'h1 << (i - 1)))
            @(posedge clk);
            master_phase <= 32'h0000_0100;
            tick(2);
            `CHK(cam_table_select, 4'h1 << i)
            @(posedge clk);
            master_phase <= 32'h0;
            apb(1'b0, cam_routing_pkg::CAMCTL_OFS, 32'h0);
            `CHK(rd, 32'h1 << use_pos[i])
        end
    endtask

    // Status bits ignore writes, unmapped address refused
    task automatic refuse_test();
        apb(1'b1, cam_routing_pkg::CAMCTL_OFS, 32'h0000_0f00);
        apb(1'b0, cam_routing_pkg::CAMCTL_OFS, 32'h0);
        `CHK(rd, 32'h1 << use_pos[3])
        apb(1'b1, 8'h40, 32'hffff_ffff);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h40, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b0, cam_routing_pkg::ROUTING_OFS, 32'h0);
        `CHK(rd, 32'h0000_f600)
        `CHK(err, 1'b0)
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        use_pos = '{cam_routing_pkg::USE_T0_POS, cam_routing_pkg::USE_T1_POS,
                    cam_routing_pkg::USE_T2_POS, cam_routing_pkg::USE_T3_POS};
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        tick(1);
        `CHK(cam_table_select, 4'h0)
        `CHK(pready, 1'b1)
        routing_test();
        immediate_test();
        armed_test();
        refuse_test();
        summarize();
    end

    // Far beyond the roughly two hundred cycles the tests take
    initial begin
        #1000000;
        num_errors++;
        summarize();
    end

endmodule
